/* src/sioled_pkg.sv */
package sioled_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] SIOLED_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SIOLED_ADDR_CHAN = 4'h1;
  localparam logic [3:0] SIOLED_ADDR_CFG = 4'h2;
  localparam logic [3:0] SIOLED_ADDR_LAMPS = 4'h3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] SIOLED_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SIOLED_CHAN_RST = 32'h0000_0000;
  localparam logic [9:0] SIOLED_DOMAIN_AUTO = 10'h000;
  localparam logic [9:0] SIOLED_NODE_AUTO = 10'h000;
  localparam logic [9:0] SIOLED_DOMAIN_MIN = 10'h001;
  localparam logic [9:0] SIOLED_DOMAIN_MAX = 10'h3E8;
  localparam logic [9:0] SIOLED_NODE_MIN = 10'h002;
  localparam logic [9:0] SIOLED_NODE_MAX = 10'h3FF;

  // ==========================================================================
  // Timebase
  // ==========================================================================
  localparam int SIOLED_CLK_MHZ = 250;
  localparam int SIOLED_SLOT_US = 50000;
  localparam int SIOLED_SLOT_CYC = SIOLED_SLOT_US * SIOLED_CLK_MHZ;
  localparam int SIOLED_FRAME_SLOTS = 24;

  // ==========================================================================
  // Modes
  // ==========================================================================
  typedef enum logic [2:0] {
    SIOLED_RUN_OFF,
    SIOLED_RUN_RESET,
    SIOLED_RUN_FWUPD,
    SIOLED_RUN_PREOP,
    SIOLED_RUN_RUN
  } sioled_run_type;

  typedef enum logic [2:0] {
    SIOLED_CPU_RUN,
    SIOLED_CPU_BOOT,
    SIOLED_CPU_PREOP,
    SIOLED_CPU_LINKBAD,
    SIOLED_CPU_PILOT,
    SIOLED_CPU_BOOTFW,
    SIOLED_CPU_FAIL_SECURE_STATE
  } sioled_cpu_type;

  typedef enum logic [1:0] {
    SIOLED_AVAIL_PERMANENT,
    SIOLED_AVAIL_OPTIONAL,
    SIOLED_AVAIL_STARTUP,
    SIOLED_AVAIL_NEVER
  } sioled_avail_type;

  typedef enum logic [2:0] {
    SIOLED_PAT_OFF,
    SIOLED_PAT_ON,
    SIOLED_PAT_SINGLE,
    SIOLED_PAT_DOUBLE,
    SIOLED_PAT_TRIPLE,
    SIOLED_PAT_BLINK,
    SIOLED_PAT_PULSE
  } sioled_pat_type;

  // Lamp bundle driven out of the block
  typedef struct packed {
    logic run_green;
    logic err_red;
    logic [3:0] chan_red;
    logic [3:0] chan_green;
    logic [1:0] pair_red;
    logic [1:0] pair_green;
    logic [1:0] safety_cpu_lamps;
  } sioled_lamps_type;

  // Startup configuration seen by the safety controller
  typedef struct packed {
    logic supervised;
    sioled_avail_type avail;
    logic [9:0] domain;
    logic [9:0] node;
  } sioled_cfg_type;

endpackage : sioled_pkg

/* src/sioled_core.sv */
// Contract
// - Green run lamp: off/single/double/blink/on by mode
// - Red error lamp: off/pulse/triple/on by state
// - Invalid firmware: red solid, green single flash
// - One state lamp pair per channel 1-4
// - Channel red: on error, blink open circuit
// - Channel green: on good, blink limit, off unused
// - All channel reds on for global faults
// - Pair red on pair warning or error; there are only pair error bits, and global faults also light it
// - Pair green follows pair signal good
// - Two lamps, one per safety processor
// - Fail-safe state lights processor lamps steadily
// - Unused module shows pre-operating pattern in place of run
// - Distinct patterns: link, boot, pilot firmware
// - Domain number 1..1000, auto by default
// - Node number 2..1023, auto by default
// - Availability never alters signal data
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module sioled_core #(
  parameter int SLOT_CYC = sioled_pkg::SIOLED_SLOT_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic io_supply_ok,
  input wire logic [3:0] chan_open,
  output sioled_pkg::sioled_lamps_type lamps,
  output sioled_pkg::sioled_cfg_type cfg
);

  // ==========================================================================
  // Shared timebase
  // ==========================================================================
  logic [31:0] slot_cnt_q;
  logic [4:0] slot_q;
  logic slot_end;

  // One slot tick drives every pattern so they stay phase aligned
  assign slot_end = (slot_cnt_q == 32'(SLOT_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      slot_cnt_q <= 32'h0000_0000;
      slot_q <= 5'h00;
    end else begin
      slot_cnt_q <= slot_end ? 32'h0000_0000 : slot_cnt_q + 32'h0000_0001;
      if (slot_end) begin
        slot_q <= (slot_q == 5'(sioled_pkg::SIOLED_FRAME_SLOTS - 1)) ? 5'h00 : slot_q + 5'h01;
      end
    end
  end

  // Pattern decode; every flash is two slots wide, so single, double and triple
  // differ in count within the 24-slot frame and the long tail keeps them apart
  function automatic logic pat_level(input sioled_pkg::sioled_pat_type pat,
                                     input logic [4:0] slot);
    begin
      case (pat)
        sioled_pkg::SIOLED_PAT_OFF: pat_level = 1'b0;
        sioled_pkg::SIOLED_PAT_ON: pat_level = 1'b1;
        sioled_pkg::SIOLED_PAT_SINGLE: pat_level = (slot < 5'h02);
        sioled_pkg::SIOLED_PAT_DOUBLE: pat_level = (slot < 5'h08) && !slot[1];
        sioled_pkg::SIOLED_PAT_TRIPLE: pat_level = (slot < 5'h0C) && !slot[1];
        sioled_pkg::SIOLED_PAT_BLINK: pat_level = slot[2];
        sioled_pkg::SIOLED_PAT_PULSE: pat_level = slot[0];
        default: pat_level = 1'b0;
      endcase
    end
  endfunction : pat_level

  // ==========================================================================
  // Registers
  // ==========================================================================
  // ctrl: [2:0] run mode, [3] bootloader, [4] safety fw update, [5] error,
  // [6] invalid fw, [7] link bad, [8] startup done, [11:9] cpu0, [14:12] cpu1
  // [15] module used by safety application
  logic [31:0] ctrl_q;
  // chan: [3:0] error, [7:4] used, [11:8] signal good, [15:12] out of limits,
  // [17:16] pair error, [19:18] pair good
  logic [31:0] chan_q;
  sioled_pkg::sioled_cfg_type cfg_q;
  logic [31:0] rdata_q;
  logic [3:0] open_s1_q;
  logic [3:0] open_q;
  logic [9:0] dom_w;
  logic [9:0] node_w;
  logic dom_ok;
  logic node_ok;

  assign dom_w = reg_wdata[21:12];
  assign node_w = reg_wdata[31:22];
  // Zero means auto assignment; out-of-range values are refused
  assign dom_ok = (dom_w == sioled_pkg::SIOLED_DOMAIN_AUTO) ||
                  ((dom_w >= sioled_pkg::SIOLED_DOMAIN_MIN) &&
                   (dom_w <= sioled_pkg::SIOLED_DOMAIN_MAX));
  assign node_ok = (node_w == sioled_pkg::SIOLED_NODE_AUTO) ||
                   (node_w >= sioled_pkg::SIOLED_NODE_MIN);

  // Register writes; a refused id leaves the stored one untouched
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= sioled_pkg::SIOLED_CTRL_RST;
      chan_q <= sioled_pkg::SIOLED_CHAN_RST;
      cfg_q.supervised <= 1'b1;
      cfg_q.avail <= sioled_pkg::SIOLED_AVAIL_PERMANENT;
      cfg_q.domain <= sioled_pkg::SIOLED_DOMAIN_AUTO;
      cfg_q.node <= sioled_pkg::SIOLED_NODE_AUTO;
    end else if (reg_wr) begin
      if (reg_addr == sioled_pkg::SIOLED_ADDR_CTRL) begin
        ctrl_q <= reg_wdata;
      end
      if (reg_addr == sioled_pkg::SIOLED_ADDR_CHAN) begin
        chan_q <= reg_wdata;
      end
      if (reg_addr == sioled_pkg::SIOLED_ADDR_CFG) begin
        cfg_q.supervised <= reg_wdata[0];
        cfg_q.avail <= sioled_pkg::sioled_avail_type'(reg_wdata[2:1]);
        if (dom_ok) begin
          cfg_q.domain <= dom_w;
        end
        if (node_ok) begin
          cfg_q.node <= node_w;
        end
      end
    end
  end

  // Open-circuit pins come from the analog side, synchronised first
  always_ff @(posedge core_clk) begin
    if (reset) begin
      open_s1_q <= 4'h0;
      open_q <= 4'h0;
    end else begin
      open_s1_q <= chan_open;
      open_q <= open_s1_q;
    end
  end

  // ==========================================================================
  // Lamp patterns
  // ==========================================================================
  sioled_pkg::sioled_run_type run_mode;
  sioled_pkg::sioled_pat_type run_pat;
  sioled_pkg::sioled_pat_type err_pat;
  sioled_pkg::sioled_cpu_type cpu_st [2];
  sioled_pkg::sioled_pat_type cpu_pat [2];
  logic invalid_fw;
  logic all_red;
  logic [3:0] ch_err;
  logic [3:0] ch_used;
  logic [3:0] ch_good;
  logic [3:0] ch_lim;
  sioled_pkg::sioled_lamps_type lamps_d;
  sioled_pkg::sioled_lamps_type lamps_q;

  assign run_mode = sioled_pkg::sioled_run_type'(ctrl_q[2:0]);
  assign invalid_fw = ctrl_q[6];
  assign ch_err = chan_q[3:0];
  assign ch_used = chan_q[7:4];
  assign ch_good = chan_q[11:8];
  assign ch_lim = chan_q[15:12];
  // Global faults override per-channel red
  assign all_red = (&ch_err) || ctrl_q[7] || !ctrl_q[8];

  // Green run lamp by mode; invalid firmware forces single flash
  assign run_pat = invalid_fw ? sioled_pkg::SIOLED_PAT_SINGLE :
                   (run_mode == sioled_pkg::SIOLED_RUN_RESET) ? sioled_pkg::SIOLED_PAT_SINGLE :
                   (run_mode == sioled_pkg::SIOLED_RUN_FWUPD) ? sioled_pkg::SIOLED_PAT_DOUBLE :
                   (run_mode == sioled_pkg::SIOLED_RUN_PREOP) ? sioled_pkg::SIOLED_PAT_BLINK :
                   (run_mode == sioled_pkg::SIOLED_RUN_RUN) ? sioled_pkg::SIOLED_PAT_ON :
                   sioled_pkg::SIOLED_PAT_OFF;

  // Red error lamp; solid states win over the animated ones
  assign err_pat = (invalid_fw || ctrl_q[5] || !io_supply_ok) ? sioled_pkg::SIOLED_PAT_ON :
                   ctrl_q[4] ? sioled_pkg::SIOLED_PAT_TRIPLE :
                   ctrl_q[3] ? sioled_pkg::SIOLED_PAT_PULSE :
                   sioled_pkg::SIOLED_PAT_OFF;

  // Each processor has its own state field
  assign cpu_st[0] = sioled_pkg::sioled_cpu_type'(ctrl_q[11:9]);
  assign cpu_st[1] = sioled_pkg::sioled_cpu_type'(ctrl_q[14:12]);

  // Processor lamp decode; unused module shows pre-operating in place of run
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!io_supply_ok) begin
        cpu_pat[i] = sioled_pkg::SIOLED_PAT_OFF;
      end else if (cpu_st[i] == sioled_pkg::SIOLED_CPU_FAIL_SECURE_STATE) begin
        cpu_pat[i] = sioled_pkg::SIOLED_PAT_ON;
      end else if (!ctrl_q[15] && (cpu_st[i] == sioled_pkg::SIOLED_CPU_RUN)) begin
        cpu_pat[i] = sioled_pkg::SIOLED_PAT_BLINK;
      end else begin
        case (cpu_st[i])
          sioled_pkg::SIOLED_CPU_RUN: cpu_pat[i] = sioled_pkg::SIOLED_PAT_OFF;
          sioled_pkg::SIOLED_CPU_BOOT: cpu_pat[i] = sioled_pkg::SIOLED_PAT_SINGLE;
          sioled_pkg::SIOLED_CPU_PREOP: cpu_pat[i] = sioled_pkg::SIOLED_PAT_BLINK;
          sioled_pkg::SIOLED_CPU_LINKBAD: cpu_pat[i] = sioled_pkg::SIOLED_PAT_DOUBLE;
          sioled_pkg::SIOLED_CPU_PILOT: cpu_pat[i] = sioled_pkg::SIOLED_PAT_PULSE;
          sioled_pkg::SIOLED_CPU_BOOTFW: cpu_pat[i] = sioled_pkg::SIOLED_PAT_TRIPLE;
          default: cpu_pat[i] = sioled_pkg::SIOLED_PAT_OFF;
        endcase
      end
    end
  end

  // Lamp levels; availability setting is not consulted here
  always_comb begin
    lamps_d.run_green = pat_level(run_pat, slot_q);
    lamps_d.err_red = pat_level(err_pat, slot_q);
    for (int c = 0; c < 4; c++) begin
      // Error solid, open circuit blinks, global fault lights all
      lamps_d.chan_red[c] = all_red || ch_err[c] || (open_q[c] && slot_q[2]);
      // Good steady, limit blinks, unused dark
      lamps_d.chan_green[c] = ch_used[c] &&
                              (ch_lim[c] ? slot_q[2] : ch_good[c]);
    end
    for (int p = 0; p < 2; p++) begin
      lamps_d.pair_red[p] = all_red || chan_q[16 + p];
      lamps_d.pair_green[p] = chan_q[18 + p];
      lamps_d.safety_cpu_lamps[p] = pat_level(cpu_pat[p], slot_q);
    end
  end

  // Lamp and read-back flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lamps_q <= '0;
      rdata_q <= 32'h0000_0000;
    end else begin
      lamps_q <= lamps_d;
      if (!reg_rd) begin
        rdata_q <= 32'h0000_0000;
      end else begin
        case (reg_addr)
          sioled_pkg::SIOLED_ADDR_CTRL: rdata_q <= ctrl_q;
          sioled_pkg::SIOLED_ADDR_CHAN: rdata_q <= chan_q;
          sioled_pkg::SIOLED_ADDR_CFG: rdata_q <= {cfg_q.node, cfg_q.domain, 9'h000,
                                                   cfg_q.avail, cfg_q.supervised};
          sioled_pkg::SIOLED_ADDR_LAMPS: rdata_q <= {12'h000, open_q, lamps_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign lamps = lamps_q;
  assign cfg = cfg_q;
  assign reg_rdata = rdata_q;

endmodule : sioled_core

/* tb/sioled_checker.sv */
module sioled_checker #(
  parameter int SLOT_CYC = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic io_supply_ok,
  input wire logic [3:0] chan_open,
  input wire sioled_pkg::sioled_lamps_type lamps,
  input wire sioled_pkg::sioled_cfg_type cfg
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Register port and lamp properties
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Configuration word accesses
  sequence s_cfg_wr; reg_wr && reg_addr == 4'h2; endsequence
  sequence s_cfg_rd; reg_rd && reg_addr == 4'h2; endsequence
  sequence s_no_supply; !io_supply_ok [*2]; endsequence
  // Fail-safe state written for processor 0 while supplied
  sequence s_fs_wr;
    reg_wr && reg_addr == 4'h0 && reg_wdata[11:9] == 3'h6 && io_supply_ok ##1 io_supply_ok;
  endsequence
  chk_fail_secure_state_lamp: assert property (s_fs_wr |=> lamps.safety_cpu_lamps[0])
    else $error("fail-safe lamp not lit");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  chk_cfg_read: assert property (s_cfg_rd |=> reg_rdata == {$past(cfg.node),
    $past(cfg.domain), 9'h0, $past(cfg.avail), $past(cfg.supervised)})
    else $error("cfg readback wrong");
  chk_unmapped_read: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_domain_range: assert property (cfg.domain <= 10'h3E8)
    else $error("domain out of range");
  chk_node_range: assert property (cfg.node != 10'h001)
    else $error("node out of range");
  chk_cfg_write: assert property (s_cfg_wr |=> cfg.supervised == $past(reg_wdata[0])
    && cfg.avail == $past(reg_wdata[2:1]))
    else $error("cfg write lost");
  chk_bad_domain: assert property (s_cfg_wr and reg_wdata[21:12] > 10'h3E8
    |=> $stable(cfg.domain))
    else $error("bad domain taken");
  chk_supply_red: assert property (s_no_supply |-> lamps.err_red)
    else $error("red lamp off without supply");
endmodule : sioled_checker

/* tb/sioled_ctrl_model.sv */
module sioled_ctrl_model (
  input wire sioled_pkg::sioled_cfg_type cfg,
  input wire logic present,
  input wire logic ready,
  output logic svc_miss,
  output logic app_go,
  output logic flag_prob,
  output logic start_mod
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Controller view of the module at startup
  // ==========================================================================
  logic required;
  // Ready stands for operational with a good safe link
  assign svc_miss = cfg.supervised && !present;
  assign required = cfg.avail == sioled_pkg::SIOLED_AVAIL_PERMANENT ||
    (cfg.avail == sioled_pkg::SIOLED_AVAIL_STARTUP && present);
  assign app_go = !required || ready;
  assign flag_prob = required && !ready;
  assign start_mod = cfg.avail != sioled_pkg::SIOLED_AVAIL_NEVER;
endmodule : sioled_ctrl_model

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Stimulus and checks
  // ==========================================================================
  localparam int SLOT = 4;
  localparam int FRAME = 24 * SLOT; // Whole frame, so counts ignore phase
  localparam logic [31:0] BASE = 32'h0000_8100; // Used by app, startup done
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic io_supply_ok = 1'b1;
  logic [3:0] chan_open = 4'h0;
  sioled_pkg::sioled_lamps_type lamps;
  sioled_pkg::sioled_cfg_type cfg;
  logic svc_miss, app_go, flag_prob, start_mod;
  int miscompares = 0;
  int tests_run = 0;
  int n [16];
  logic [31:0] q;
  sioled_core #(.SLOT_CYC(SLOT)) u_sioled_core (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .io_supply_ok(io_supply_ok), .chan_open(chan_open),
    .lamps(lamps), .cfg(cfg));
  sioled_ctrl_model u_sioled_ctrl_model (.cfg(cfg), .present(1'b1), .ready(1'b0),
    .svc_miss(svc_miss), .app_go(app_go), .flag_prob(flag_prob), .start_mod(start_mod));
  // Clock and watchdog; the run needs about 2500 cycles
  initial forever #2 core_clk = ~core_clk;
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  // Bus cycles start and end just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  // Write, let sync flops settle, then count lit cycles of each lamp
  task automatic look(input logic [3:0] a, input logic [31:0] d);
    wr(a, d);
    repeat (4) @(posedge core_clk);
    n = '{default: 0};
    repeat (FRAME) begin
      #1;
      for (int i = 0; i < 16; i++) n[i] += int'(lamps[i]);
      @(posedge core_clk);
    end
  endtask : look
  task automatic t_run();
    int e [5] = '{0, 8, 16, 48, 96};
    int single = 0;
    for (int m = 0; m < 5; m++) begin
      look(4'h0, BASE | m);
      check(n[15], e[m]);
      if (m == 1) single = n[15];
      if (m == 2) check(n[15] != single, 1);
    end
    $display("t_run done");
  endtask : t_run
  task automatic t_err();
    int e [4] = '{48, 24, 96, 0};
    logic [31:0] c [4] = '{32'h8, 32'h10, 32'h20, 32'h0};
    for (int i = 0; i < 4; i++) begin
      look(4'h0, BASE | 4 | c[i]);
      check(n[14], e[i]);
    end
    look(4'h0, BASE | 32'h44);
    check(n[14], 96);
    check(n[15], 8);
    io_supply_ok <= 1'b0;
    look(4'h0, BASE | 4);
    check(n[14], 96);
    io_supply_ok <= 1'b1;
    $display("t_err done");
  endtask : t_err
  task automatic t_chan();
    int e [12] = '{0, 96, 96, 0, 0, 0, 96, 48, 96, 48, 0, 0};
    look(4'h0, BASE | 4);
    chan_open <= 4'h2;
    look(4'h1, 32'h0009_84E1);
    for (int i = 2; i < 14; i++) check(n[i], e[i-2]);
    rd(4'h3, q);
    check(q[19:16], 4'h2);
    look(4'h2, 32'h0000_0002);
    check(n[8] + n[4], 192);
    for (int k = 0; k < 2; k++) begin
      look(4'h0, k ? (BASE | 32'h84) : 32'h8004);
      for (int i = 10; i < 14; i++) check(n[i], 96);
    end
    chan_open <= 4'h0;
    $display("t_chan done");
  endtask : t_chan
  task automatic t_cpu();
    for (int c = 0; c < 7; c++) begin
      look(4'h0, BASE | 4 | (c << 9));
      check(n[0] * n[1], 0);
      if (c == 0) check(n[0] + n[1], 0);
      else if (c == 6) check(n[0] + n[1], 96);
      else check(n[0] + n[1] > 0 && n[0] + n[1] < 96, 1);
    end
    look(4'h0, 32'h0000_0104);
    check(n[0] + n[1], 96);
    $display("t_cpu done");
  endtask : t_cpu
  task automatic t_cfg();
    logic [31:0] w [3] = '{32'hFFFE_8006, 32'h007E_9003, 32'h0080_1000};
    logic [31:0] x [3] = '{32'hFFFE_8006, 32'hFFFE_8003, 32'h0080_1000};
    rd(4'h2, q);
    check(q, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(4'h2, w[i]);
      rd(4'h2, q);
      check(q, x[i]);
      if (i == 0) check(start_mod, 0);
      if (i == 0) check({svc_miss, app_go, flag_prob}, 3'b010);
      if (i == 2) check({svc_miss, app_go, flag_prob}, 3'b001);
    end
    wr(4'h9, 32'hFFFF_FFFF);
    rd(4'h9, q);
    check(q, 32'h0);
    rd(4'h2, q);
    check(q, x[2]);
    $display("t_cfg done");
  endtask : t_cfg
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // Main sequence, with a second reset before the configuration test
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_run();
    t_err();
    t_chan();
    t_cpu();
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_cfg();
    complete_run();
  end
endmodule : tb_top
bind sioled_core sioled_checker #(.SLOT_CYC(SLOT_CYC)) u_sioled_checker (.core_clk(core_clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_supply_ok(io_supply_ok),
  .chan_open(chan_open), .lamps(lamps), .cfg(cfg));
